/* File: src/hpc_field_split.sv */
`timescale 1ns/1ps
`default_nettype none
// splits the downstream drive byte into per-port boost codes
module hpc_field_split
	import hpc_pkg::*;
#(
	parameter int NUM_DN = HPC_NUM_DN
) (
	input  wire logic [7:0]             dn_drive, // downstream drive byte
	output var  hpc_pkg::hpc_boost_e [NUM_DN-1:0] codes // per-port codes
);
	genvar g;
	// port g+1 takes bits 2g+1:2g
	generate
		for (g = 0; g < NUM_DN; g++) begin : g_port
			assign codes[g] = hpc_boost_e'(dn_drive[g*HPC_CODE_W +: HPC_CODE_W]); // R5 R6 R7 R8
		end
	endgenerate
endmodule
`default_nettype wire

/* File: src/hpc_pkg.sv */
package hpc_pkg;
	// configuration map byte offsets
	localparam logic [7:0] HPC_ADDR_CHARGE    = 8'hd0;
	localparam logic [7:0] HPC_ADDR_UP_DRIVE  = 8'hf6;
	localparam logic [7:0] HPC_ADDR_DN_DRIVE  = 8'hf8;
	// writable bit masks; reserved bits stay zero
	localparam logic [7:0] HPC_MASK_CHARGE    = 8'h1e;
	localparam logic [7:0] HPC_MASK_UP_DRIVE  = 8'h03;
	localparam logic [7:0] HPC_MASK_DN_DRIVE  = 8'hff;
	// reset values
	localparam logic [7:0] HPC_RST_CHARGE     = 8'h00;
	localparam logic [7:0] HPC_RST_DRIVE      = 8'h00;
	localparam logic [7:0] HPC_RD_NONE        = 8'h00;
	// field layout
	localparam int         HPC_NUM_DN         = 4;
	localparam int         HPC_CHARGE_LSB     = 1;
	localparam int         HPC_CODE_W         = 2;

	// drive boost levels
	typedef enum logic [1:0] {
		HPC_BOOST_NONE = 2'h0,
		HPC_BOOST_LOW  = 2'h1,
		HPC_BOOST_MED  = 2'h2,
		HPC_BOOST_HIGH = 2'h3
	} hpc_boost_e;

	// one configuration bus access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpc_req_s;

	// per-port settings handed to transceivers and charging logic
	typedef struct packed {
		hpc_boost_e                  up_code;
		hpc_boost_e [HPC_NUM_DN-1:0] dn_code;
		logic       [HPC_NUM_DN-1:0] charge_en;
	} hpc_cfg_s;

	// register state of the bank
	typedef struct packed {
		logic [7:0] charge;
		logic [7:0] up_drive;
		logic [7:0] dn_drive;
		logic [7:0] rdata;
		logic       rvalid;
	} hpc_state_s;
endpackage

/* File: src/hpc_port_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - a port's charging support is enabled only while its enable bit is 1
// R2 - charging enable bits 1 to 4 map to ports 1 to 4; 0,5-7 reserved
// R3 - upstream drive register bits 1:0 are the upstream boost code
// R4 - codes 00 none, 01 low, 10 medium, 11 high boost
// R5 - downstream drive bits 7:6 drive port 4 boost code
// R6 - downstream drive bits 5:4 drive port 3 boost code
// R7 - downstream drive bits 3:2 drive port 2 boost code
// R8 - downstream drive bits 1:0 drive port 1 boost code
// R9 - configurer should program no boost unless the board needs it
// R10 - downstream drive register sits at offset f8
// R11 - reserved bits read zero, ignore writes; boost codes reset to none
module hpc_port_cfg
	import hpc_pkg::*;
#(
	parameter int NUM_DN = HPC_NUM_DN
) (
	input  wire logic                     clk,       // core clock, 250 MHz
	input  wire logic                     rstn,      // synchronous reset, active low
	input  wire hpc_pkg::hpc_req_s        req,       // configuration access
	output var  logic [7:0]               rdata,     // read data, one cycle after rd
	output var  logic                     rvalid,    // read data valid pulse
	output var  logic [NUM_DN-1:0]        charge_en, // per-port charging enable
	output var  hpc_pkg::hpc_boost_e      up_code,   // upstream boost code
	output var  hpc_pkg::hpc_boost_e [NUM_DN-1:0] dn_code // downstream boost codes
);
	import hpc_pkg::*;

	hpc_state_s                   st;
	hpc_state_s                   next_st;
	hpc_boost_e [NUM_DN-1:0]      split_codes;

	// read-side mux, used for the read path only
	function automatic logic [7:0] read_mux(input hpc_state_s s, input logic [7:0] a);
		logic [7:0] v;
		v = HPC_RD_NONE;
		if (a == HPC_ADDR_CHARGE) begin
			v = s.charge;
		end else if (a == HPC_ADDR_UP_DRIVE) begin
			v = s.up_drive;
		end else if (a == HPC_ADDR_DN_DRIVE) begin // R10
			v = s.dn_drive;
		end
		return v;
	endfunction

	// true for the three mapped offsets; used by the unmapped read check below
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == HPC_ADDR_CHARGE) || (a == HPC_ADDR_UP_DRIVE) || (a == HPC_ADDR_DN_DRIVE);
	endfunction

	// write decode; reserved bits masked so they never store
	always_comb begin
		next_st        = st;
		next_st.rvalid = req.rd;
		next_st.rdata  = req.rd ? read_mux(st, req.addr) : HPC_RD_NONE;
		if (req.wr) begin
			if (req.addr == HPC_ADDR_CHARGE) begin
				next_st.charge = req.wdata & HPC_MASK_CHARGE; // R2 R11
			end else if (req.addr == HPC_ADDR_UP_DRIVE) begin
				next_st.up_drive = req.wdata & HPC_MASK_UP_DRIVE; // R3 R11
			end else if (req.addr == HPC_ADDR_DN_DRIVE) begin
				next_st.dn_drive = req.wdata & HPC_MASK_DN_DRIVE; // R10
			end
		end
		if (!rstn) begin
			next_st.charge   = HPC_RST_CHARGE;
			next_st.up_drive = HPC_RST_DRIVE; // R11
			next_st.dn_drive = HPC_RST_DRIVE; // R11
			next_st.rdata    = HPC_RD_NONE;
			next_st.rvalid   = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	hpc_field_split #(
		.NUM_DN (NUM_DN)
	) u_split (
		.dn_drive (next_st.dn_drive),
		.codes    (split_codes)
	);

	// outputs registered; they follow the stored bytes in the same edge
	always_ff @(posedge clk) begin
		rdata     <= next_st.rdata;
		rvalid    <= next_st.rvalid;
		charge_en <= next_st.charge[HPC_CHARGE_LSB +: NUM_DN]; // R1 R2
		up_code   <= hpc_boost_e'(next_st.up_drive[HPC_CODE_W-1:0]); // R3 R4
		dn_code   <= split_codes; // R4 R5 R6 R7 R8
	end

	// R9 is the configurer's choice; reset leaves every port at no boost
	chk_charge_follows_bit: assert property (@(posedge clk) disable iff (!rstn) // R1
		(req.wr && req.addr == HPC_ADDR_CHARGE) |=> charge_en == $past(req.wdata[4:1]))
		else $error("charge enable does not follow written bits");
	chk_charge_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn) // R2
		rvalid && $past(req.addr) == HPC_ADDR_CHARGE |-> (rdata & ~HPC_MASK_CHARGE) == 8'h00)
		else $error("charge reserved bits read nonzero");
	chk_up_code_write: assert property (@(posedge clk) disable iff (!rstn) // R3
		(req.wr && req.addr == HPC_ADDR_UP_DRIVE) |=> up_code == $past(req.wdata[1:0]))
		else $error("upstream code not taken from bits 1:0");
	chk_port4_code: assert property (@(posedge clk) disable iff (!rstn) // R5
		(req.wr && req.addr == HPC_ADDR_DN_DRIVE) |=> dn_code[3] == $past(req.wdata[7:6]))
		else $error("port 4 code wrong");
	chk_port3_code: assert property (@(posedge clk) disable iff (!rstn) // R6
		(req.wr && req.addr == HPC_ADDR_DN_DRIVE) |=> dn_code[2] == $past(req.wdata[5:4]))
		else $error("port 3 code wrong");
	chk_port2_code: assert property (@(posedge clk) disable iff (!rstn) // R7
		(req.wr && req.addr == HPC_ADDR_DN_DRIVE) |=> dn_code[1] == $past(req.wdata[3:2]))
		else $error("port 2 code wrong");
	chk_port1_code: assert property (@(posedge clk) disable iff (!rstn) // R8
		(req.wr && req.addr == HPC_ADDR_DN_DRIVE) |=> dn_code[0] == $past(req.wdata[1:0]))
		else $error("port 1 code wrong");
	sequence s_dn_write;
		req.wr && req.addr == HPC_ADDR_DN_DRIVE && !req.rd ##1 req.rd && !req.wr
			&& req.addr == HPC_ADDR_DN_DRIVE;
	endsequence
	chk_dn_readback: assert property (@(posedge clk) disable iff (!rstn) // R10
		s_dn_write |=> rvalid && rdata == $past(req.wdata, 2))
		else $error("downstream drive readback mismatch");
	chk_reset_no_boost: assert property (@(posedge clk) // R11 R4
		!rstn |=> up_code == HPC_BOOST_NONE && dn_code == '0 && charge_en == '0)
		else $error("reset did not clear codes");
	chk_up_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn) // R11
		rvalid && $past(req.addr) == HPC_ADDR_UP_DRIVE |-> rdata[7:2] == 6'h00)
		else $error("upstream reserved bits read nonzero");

	// read answer comes one cycle after the strobe and stands one cycle only
	chk_rvalid_after_rd: assert property (@(posedge clk) disable iff (!rstn) // R10
		req.rd |=> rvalid)
		else $error("no read valid after read strobe");
	chk_rvalid_one_cycle: assert property (@(posedge clk) disable iff (!rstn) // R11
		!req.rd |=> !rvalid && rdata == HPC_RD_NONE)
		else $error("read answer without read strobe");
	// unmapped offsets answer zero so a loader probing the map sees nothing
	chk_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rstn) // R11
		req.rd && !is_mapped(req.addr) |=> rdata == HPC_RD_NONE)
		else $error("unmapped read returned data");
	// settings only move on a write to their own offset
	chk_charge_holds: assert property (@(posedge clk) disable iff (!rstn) // R1
		!(req.wr && req.addr == HPC_ADDR_CHARGE) |=> $stable(charge_en))
		else $error("charge enable moved without a write");
	chk_up_code_holds: assert property (@(posedge clk) disable iff (!rstn) // R3
		!(req.wr && req.addr == HPC_ADDR_UP_DRIVE) |=> $stable(up_code))
		else $error("upstream code moved without a write");
	chk_dn_code_holds: assert property (@(posedge clk) disable iff (!rstn) // R10
		!(req.wr && req.addr == HPC_ADDR_DN_DRIVE) |=> $stable(dn_code))
		else $error("downstream codes moved without a write");
	// reserved-only writes must leave every port without charging
	chk_charge_rsvd_ignored: assert property (@(posedge clk) disable iff (!rstn) // R2
		req.wr && req.addr == HPC_ADDR_CHARGE && (req.wdata & HPC_MASK_CHARGE) == 8'h00
		|=> charge_en == '0)
		else $error("reserved charge bits reached a port");
	// a read in the cycle of a write sees the value from before it
	chk_rd_sees_old: assert property (@(posedge clk) disable iff (!rstn) // R10
		req.wr && req.rd && req.addr == HPC_ADDR_DN_DRIVE |=> rdata == 8'($past(dn_code)))
		else $error("same-cycle read did not return old value");
endmodule
`default_nettype wire

/* File: verification/hpc_cfg_master.sv */
`timescale 1ns/1ps
`default_nettype none
// configuration master: one-cycle strobes, dropped after the taking edge
module hpc_cfg_master
	import hpc_pkg::*;
(
	input  wire logic             clk,    // core clock
	input  wire logic [7:0]       rdata,  // read data
	input  wire logic             rvalid, // read valid pulse
	output var  hpc_pkg::hpc_req_s req    // access strobes
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) req <= '0;
		#1;
	endtask
	// read data is taken one cycle after the strobe, once the edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk) req <= '0;
		#1 d = rdata;
		v = rvalid;
	endtask
	// write then read the same offset on the next cycle, back to back
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic v);
		@(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk) req <= '0;
		#1 q = rdata;
		v = rvalid;
	endtask
	// write and read strobes in one cycle; read returns the old value
	task automatic wr_and_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic v);
		@(posedge clk) req <= '{wr: 1'b1, rd: 1'b1, addr: a, wdata: d};
		@(posedge clk) req <= '0;
		#1 q = rdata;
		v = rvalid;
	endtask
	// recommended setting: no boost unless the board needs it
	task automatic no_boost();
		wr(HPC_ADDR_UP_DRIVE, 8'h00);
		wr(HPC_ADDR_DN_DRIVE, 8'h00);
	endtask
endmodule
`default_nettype wire

/* File: verification/hpc_port_cfg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hpc_port_cfg_tb;
	import hpc_pkg::*;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic [7:0]       rdata;
	logic             rvalid;
	logic [3:0]       charge_en;
	hpc_boost_e       up_code;
	hpc_boost_e [3:0] dn_code;
	hpc_req_s         req;
	int               mismatches = 0;
	int               tests_run = 0;
	hpc_port_cfg #(.NUM_DN(4)) hpc_port_cfg_i (.clk(clk), .rstn(rstn), .req(req),
		.rdata(rdata), .rvalid(rvalid), .charge_en(charge_en), .up_code(up_code),
		.dn_code(dn_code));
	hpc_cfg_master hpc_cfg_master_i (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// read back through the bus; rvalid must pulse with the data
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		hpc_cfg_master_i.rd(a, d, v);
		cmp("rvalid", 8'h01, {7'h00, v});
		cmp("rdata", e, d);
	endtask
	task automatic t_reset();
		cmp("charge_en", 8'h00, {4'h0, charge_en});
		cmp("up_code", 8'h00, {6'h00, up_code});
		cmp("dn_code", 8'h00, 8'(dn_code));
		$display("test reset done");
	endtask
	// one port at a time, then reserved bits alone
	task automatic t_charge();
		for (int i = 0; i < 4; i++) begin
			hpc_cfg_master_i.wr(HPC_ADDR_CHARGE, 8'h02 << i);
			cmp("charge_en", 8'h01 << i, {4'h0, charge_en});
		end
		hpc_cfg_master_i.wr(HPC_ADDR_CHARGE, 8'he1);
		cmp("charge_en", 8'h00, {4'h0, charge_en});
		hpc_cfg_master_i.wr(HPC_ADDR_CHARGE, 8'hff);
		rchk(HPC_ADDR_CHARGE, 8'h1e);
		$display("test charge done");
	endtask
	// every code with reserved bits set around it
	task automatic t_drive();
		for (int c = 0; c < 4; c++) begin
			hpc_cfg_master_i.wr(HPC_ADDR_UP_DRIVE, 8'hfc | 8'(c));
			cmp("up_code", 8'(c), {6'h00, up_code});
			rchk(HPC_ADDR_UP_DRIVE, 8'(c));
		end
		hpc_cfg_master_i.wr(HPC_ADDR_DN_DRIVE, 8'he4);
		cmp("dn_code", 8'he4, 8'(dn_code));
		rchk(HPC_ADDR_DN_DRIVE, 8'he4);
		hpc_cfg_master_i.wr(8'hf7, 8'h00);
		rchk(8'hf7, 8'h00);
		cmp("dn_code", 8'he4, 8'(dn_code));
		hpc_cfg_master_i.no_boost();
		cmp("dn_code", 8'h00, 8'(dn_code));
		$display("test drive done");
	endtask
	// back-to-back and same-cycle accesses, then the answer must drop
	task automatic t_order();
		logic [7:0] q;
		logic       v;
		hpc_cfg_master_i.wr_rd(HPC_ADDR_DN_DRIVE, 8'h1b, q, v);
		cmp("rvalid", 8'h01, {7'h00, v});
		cmp("rdata", 8'h1b, q);
		hpc_cfg_master_i.wr_and_rd(HPC_ADDR_DN_DRIVE, 8'h6c, q, v);
		cmp("rdata", 8'h1b, q);
		cmp("dn_code", 8'h6c, 8'(dn_code));
		@(posedge clk);
		#1;
		cmp("rvalid", 8'h00, {7'h00, rvalid});
		cmp("rdata", 8'h00, rdata);
		$display("test order done");
	endtask
	// reset in mid-run returns every port to no boost and no charging
	task automatic t_mid_reset();
		hpc_cfg_master_i.wr(HPC_ADDR_UP_DRIVE, 8'h03);
		hpc_cfg_master_i.wr(HPC_ADDR_CHARGE, 8'h1e);
		hpc_cfg_master_i.wr(HPC_ADDR_DN_DRIVE, 8'hff);
		@(posedge clk) rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		cmp("charge_en", 8'h00, {4'h0, charge_en});
		cmp("up_code", 8'h00, {6'h00, up_code});
		cmp("dn_code", 8'h00, 8'(dn_code));
		rchk(HPC_ADDR_DN_DRIVE, 8'h00);
		$display("test mid reset done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		#1;
		t_reset();
		t_charge();
		t_drive();
		t_order();
		t_mid_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
